// File: pkg/dram_host_pkg.sv
// constants for the strobe-level dram host controller
package dram_host_pkg;
    // ----------------------------------------
    // clock and geometry
    // ----------------------------------------
    localparam int CLK_MHZ        = 20;
    localparam int CLK_NS         = 50;
    localparam int ADDR_W         = 11;
    localparam int ROW_COUNT      = 1024;
    // ----------------------------------------
    // power-up (figures in their own unit, then cycles)
    // ----------------------------------------
    localparam int POWERUP_US       = 100;
    localparam int POWERUP_CYC      = POWERUP_US * CLK_MHZ;
    localparam int WAKE_STROBES     = 8;
    // ----------------------------------------
    // refresh interval, rounded down
    // ----------------------------------------
    localparam int REFRESH_US       = 32;
    localparam int REFRESH_CYC      = REFRESH_US * CLK_MHZ;
    // ----------------------------------------
    // strobe phases, least times rounded up
    // ----------------------------------------
    localparam int RAS_LOW_NS       = 80;
    localparam int RAS_PRE_NS       = 70;
    localparam int ROW_TO_WRITE_NS  = 80;
    localparam int READ_HOLD_ROW_NS = 10;
    localparam int WRITE_PULSE_NS   = 15;
    localparam int CAS_PRE_CBR_NS   = 20;
    localparam int CAS_ROW_CBR_NS   = 40;
    localparam int SELF_CYCLE_NS    = 360;
    localparam int SELF_LOW_NS      = 150;
    localparam int SELF_HIGH_NS     = 200;
    localparam int SELF_CAS_NS      = 360;
    localparam int EXIT_CAS_NS      = 100;
    localparam int EXIT_ROW_NS      = 200;
    localparam int SELF_RATE_KHZ    = 128;
    localparam int SELF_PERIOD_CYC  = (CLK_MHZ * 1000) / SELF_RATE_KHZ;
    function automatic int cyc_up(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS < 1 ? 1 : (ns + CLK_NS - 1) / CLK_NS;
    endfunction
    localparam int RAS_LOW_CYC      = cyc_up(RAS_LOW_NS);
    localparam int RAS_PRE_CYC      = cyc_up(RAS_PRE_NS);
    localparam int ROW_TO_WRITE_CYC = cyc_up(ROW_TO_WRITE_NS);
    localparam int READ_HOLD_CYC    = cyc_up(READ_HOLD_ROW_NS);
    localparam int WRITE_PULSE_CYC  = cyc_up(WRITE_PULSE_NS);
    localparam int CAS_PRE_CBR_CYC  = cyc_up(CAS_PRE_CBR_NS);
    localparam int CAS_ROW_CBR_CYC  = cyc_up(CAS_ROW_CBR_NS);
    localparam int SELF_LOW_CYC     = cyc_up(SELF_LOW_NS);
    localparam int SELF_HIGH_CYC    = cyc_up(SELF_HIGH_NS);
    localparam int SELF_CYCLE_CYC   = cyc_up(SELF_CYCLE_NS);
    localparam int SELF_CAS_CYC     = cyc_up(SELF_CAS_NS);
    localparam int EXIT_CAS_CYC     = cyc_up(EXIT_CAS_NS);
    localparam int EXIT_ROW_CYC     = cyc_up(EXIT_ROW_NS);
    localparam int CNT_W            = 16;
    // ----------------------------------------
    // controller states
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_POWER, ST_WAKE_LO, ST_WAKE_HI, ST_IDLE,
        ST_ROW, ST_COL, ST_WLATE, ST_HOLD, ST_PRE,
        ST_CBR_CAS, ST_CBR_RAS, ST_SELF_LO, ST_SELF_HI, ST_EXIT
    } host_state_e;
endpackage

// File: design/dram_host.sv
// strobe-level host controller for a 4m x 1 fast-page dram
`timescale 1ns/1ns
// Function
// RL1 - wait power-up pause, then eight row strobe cycles before use
// RL2 - after power-up run one column-first refresh with write high
// RL3 - column-first refresh with write low enters test mode; keep write high
// RL4 - write low before column fall makes early write, output stays off
// RL5 - write late after row, column, address gives read-write cycle
// RL6 - neither write timing met: output undefined until column rises
// RL7 - data referenced to column fall (early) or write fall (late)
// RL8 - read keeps write high for hold after row rises
// RL9 - late write pulse at least 15 ns; early write meets setup and hold
// RL10 - use column-first refresh every 32 us during normal operation
// RL11 - device counter supplies refresh rows across both refresh modes
// RL12 - other refresh means need burst refresh around self-refresh
// RL13 - self-refresh row strobe keeps at least minimum temperature rate
// RL14 - self-refresh row cycle 360 ns, low 150 ns, high 200 ns
// RL15 - column strobe held low at least 360 ns in self-refresh
// RL16 - on exit column high 100 ns and row precharge 200 ns
// RL17 - between column-first refreshes precharge 20 ns and 40 ns
// RL18 - gap between self pulses and column-first refreshes within cycle limit
// RL19 - read data held while column low, released when column rises
// RL20 - any refresh scheme must cover all 1024 rows per period
// RL21 - self-refresh: column before row, column held low; exit by raising it
module dram_host
    import dram_host_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC,
    parameter int REFRESH_CYCLES = REFRESH_CYC
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // user request side
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic              req_late,
    input  wire logic [ADDR_W-1:0] req_row,
    input  wire logic [ADDR_W-1:0] req_col,
    input  wire logic              req_wdata,
    output logic                   rd_valid,
    output logic                   rd_data,
    input  wire logic              self_req,
    output logic                   mem_ready,
    output logic                   in_self,
    // dram pins
    output logic                   row_strobe_n,
    output logic                   column_strobe_n,
    output logic                   write_strobe_n,
    output logic [ADDR_W-1:0]      addr,
    output logic                   din,
    input  wire logic              dout
);
    // ----------------------------------------
    // state and registers
    // ----------------------------------------
    host_state_e       state_reg, state_next;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  ref_reg;
    logic [3:0]        wake_reg;
    logic              init_done_reg, ref_due_reg, op_write_reg, op_late_reg;
    logic [ADDR_W-1:0] col_reg;
    logic              dout_s1_reg, dout_s2_reg;
    logic              rd_take_reg;
    logic              self_s1_reg, self_s2_reg;
    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire cnt_zero  = (cnt_reg == '0);
    wire ref_tick  = (ref_reg == '0);
    wire take_req  = (state_reg == ST_IDLE) && init_done_reg && !ref_due_reg && !self_s2_reg && req_valid;
    wire go_cbr    = (state_reg == ST_IDLE) && (ref_due_reg || !init_done_reg); // RL2 RL10
    wire go_self   = (state_reg == ST_IDLE) && init_done_reg && self_s2_reg && !ref_due_reg;
    assign req_ready = take_req;
    assign mem_ready = init_done_reg;

    function automatic logic [CNT_W-1:0] ld(input int n);
        return CNT_W'(n - 1);
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic [CNT_W-1:0] cnt_next;
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_zero ? '0 : cnt_reg - 1'b1;
        case (state_reg)
            ST_POWER:   if (cnt_zero) begin // RL1
                state_next = ST_WAKE_LO;
                cnt_next   = ld(RAS_LOW_CYC);
            end
            ST_WAKE_LO: if (cnt_zero) begin
                state_next = ST_WAKE_HI;
                cnt_next   = ld(RAS_PRE_CYC);
            end
            ST_WAKE_HI: if (cnt_zero) begin // RL1
                state_next = (wake_reg == 4'(WAKE_STROBES - 1)) ? ST_IDLE : ST_WAKE_LO;
                cnt_next   = ld(RAS_LOW_CYC);
            end
            ST_IDLE: begin
                if (go_cbr) begin
                    state_next = ST_CBR_CAS;
                    cnt_next   = ld(CAS_ROW_CBR_CYC);
                end else if (go_self) begin
                    state_next = ST_SELF_LO; // RL21 RL18
                    cnt_next   = ld(SELF_LOW_CYC + 1);
                end else if (take_req) begin
                    state_next = ST_ROW;
                    cnt_next   = ld(ROW_TO_WRITE_CYC);
                end
            end
            ST_ROW:     if (cnt_zero) begin
                state_next = ST_COL;
                cnt_next   = ld(WRITE_PULSE_CYC);
            end
            ST_COL:     if (cnt_zero) begin
                state_next = (op_write_reg && op_late_reg) ? ST_WLATE : ST_HOLD;
                cnt_next   = ld(WRITE_PULSE_CYC);
            end
            ST_WLATE:   if (cnt_zero) begin // RL9
                state_next = ST_HOLD;
                cnt_next   = ld(READ_HOLD_CYC);
            end
            ST_HOLD:    if (cnt_zero) begin // RL8
                state_next = ST_PRE;
                cnt_next   = ld(RAS_PRE_CYC);
            end
            ST_PRE:     if (cnt_zero) state_next = ST_IDLE;
            ST_CBR_CAS: if (cnt_zero) begin // RL17
                state_next = ST_CBR_RAS;
                cnt_next   = ld(RAS_LOW_CYC);
            end
            ST_CBR_RAS: if (cnt_zero) begin
                state_next = ST_PRE;
                cnt_next   = ld(CAS_ROW_CBR_CYC);
            end
            ST_SELF_LO: if (cnt_zero) begin // RL14 RL15
                state_next = ST_SELF_HI;
                cnt_next   = ld(SELF_PERIOD_CYC - SELF_LOW_CYC);
            end
            ST_SELF_HI: if (cnt_zero) begin // RL13
                state_next = self_s2_reg ? ST_SELF_LO : ST_EXIT;
                cnt_next   = self_s2_reg ? ld(SELF_LOW_CYC) : ld(EXIT_ROW_CYC);
            end
            ST_EXIT:    if (cnt_zero) begin // RL16
                state_next = ST_CBR_CAS;
                cnt_next   = ld(CAS_ROW_CBR_CYC);
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // strobe decode: pins go out registered
    // ----------------------------------------
    wire op_write_next = take_req ? req_write : op_write_reg;
    wire op_late_next  = take_req ? req_late : op_late_reg;
    // on self entry the row strobe waits a cycle so the column strobe clearly leads it
    wire ras_lo_next = (state_next inside {ST_WAKE_LO, ST_ROW, ST_COL, ST_WLATE, ST_CBR_RAS})
                       || (state_next == ST_SELF_LO && state_reg != ST_IDLE) // RL21
                       || (state_next == ST_HOLD && !op_write_reg);
    // column leads row in every refresh, the one after self-refresh exit too
    wire cas_lo_next = state_next inside {ST_COL, ST_WLATE, ST_CBR_CAS, ST_CBR_RAS, // RL21
                                          ST_SELF_LO, ST_SELF_HI};
    // write only drops for real writes; refreshes keep it high to avoid test mode
    wire we_lo_next  = (state_next == ST_ROW && op_write_next && !op_late_next)       // RL4 RL3
                       || (state_next == ST_COL && op_write_reg && !op_late_reg)
                       || (state_next == ST_WLATE);                                      // RL5 RL7

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_POWER;
            cnt_reg   <= CNT_W'(POWERUP_CYCLES - 1);
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wake_reg      <= 4'h0;
            init_done_reg <= 1'b0;
        end else if (state_reg == ST_WAKE_HI && cnt_zero) begin
            wake_reg <= wake_reg + 4'h1;
        end else if (state_reg == ST_CBR_RAS && cnt_zero) begin
            init_done_reg <= 1'b1; // RL2
        end
    end

    // refresh timer: a due flag is set on tick and set beats clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_reg     <= CNT_W'(REFRESH_CYCLES - 1);
            ref_due_reg <= 1'b0;
        end else begin
            ref_reg     <= (ref_tick || state_reg inside {ST_SELF_LO, ST_SELF_HI}) ? CNT_W'(REFRESH_CYCLES - 1)
                           : ref_reg - 1'b1; // RL10 RL20 RL12
            ref_due_reg <= (ref_tick && !(state_reg inside {ST_SELF_LO, ST_SELF_HI}))
                           || (ref_due_reg && !go_cbr);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_write_reg <= 1'b0;
            op_late_reg  <= 1'b0;
            col_reg      <= '0;
            din          <= 1'b0;
        end else if (take_req) begin
            op_write_reg <= req_write;
            op_late_reg  <= req_late;
            col_reg      <= req_col;
            din          <= req_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            row_strobe_n    <= 1'b1;
            column_strobe_n <= 1'b1;
            write_strobe_n  <= 1'b1;
            addr            <= '0;
        end else begin
            row_strobe_n    <= !ras_lo_next;
            column_strobe_n <= !cas_lo_next;
            write_strobe_n  <= !we_lo_next;
            addr            <= take_req ? req_row : (state_next == ST_COL ? col_reg : addr);
        end
    end

    // pins are synchronised before any logic looks at them
    always_ff @(posedge clk) begin
        if (rst) begin
            dout_s1_reg <= 1'b0;
            dout_s2_reg <= 1'b0;
            self_s1_reg <= 1'b0;
            self_s2_reg <= 1'b0;
        end else begin
            dout_s1_reg <= dout;
            dout_s2_reg <= dout_s1_reg;
            self_s1_reg <= self_req;
            self_s2_reg <= self_s1_reg;
        end
    end

    // read data reaches the second sync flop as hold ends, so take it one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_take_reg <= 1'b0;
            rd_valid <= 1'b0;
            rd_data  <= 1'b0;
            in_self  <= 1'b0;
        end else begin
            rd_take_reg <= (state_reg == ST_HOLD) && cnt_zero && !op_write_reg;
            rd_valid <= rd_take_reg; // RL19 RL6
            rd_data  <= rd_take_reg ? dout_s2_reg : rd_data;
            in_self  <= state_next inside {ST_SELF_LO, ST_SELF_HI};
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [CNT_W-1:0] self_hi_run;
    always_ff @(posedge clk) begin
        if (rst) self_hi_run <= '0;
        else self_hi_run <= (in_self && row_strobe_n) ? self_hi_run + 1'b1 : '0;
    end

    no_early_use_a: assert property (@(posedge clk) disable iff (rst) // RL1
        (state_reg == ST_POWER) |-> !req_ready) else $error("request taken during power-up");
    cbr_we_high_a: assert property (@(posedge clk) disable iff (rst) // RL3
        (!column_strobe_n && $fell(row_strobe_n) && state_reg inside {ST_CBR_RAS, ST_SELF_LO}) |-> write_strobe_n)
        else $error("write low during column-first refresh");
    cbr_cas_first_a: assert property (@(posedge clk) disable iff (rst) // RL21
        $fell(row_strobe_n) && state_reg inside {ST_CBR_RAS, ST_SELF_LO} |-> !$past(column_strobe_n))
        else $error("row fell before column in refresh");
    read_we_high_a: assert property (@(posedge clk) disable iff (rst) // RL8
        (state_reg == ST_HOLD && !op_write_reg) |-> write_strobe_n) else $error("write low in read");
    late_pulse_a: assert property (@(posedge clk) disable iff (rst) // RL9 RL5
        $fell(write_strobe_n) && op_late_reg |-> !row_strobe_n && !column_strobe_n && !$past(row_strobe_n, 2))
        else $error("late write pulse outside its strobes");
    self_low_a: assert property (@(posedge clk) disable iff (rst) // RL14
        $fell(row_strobe_n) && in_self |-> !row_strobe_n [*3]) else $error("self row low too short");
    self_rate_a: assert property (@(posedge clk) disable iff (rst) // RL13
        self_hi_run <= CNT_W'(SELF_PERIOD_CYC)) else $error("self refresh rate too low");
    refresh_taken_a: assert property (@(posedge clk) disable iff (rst) // RL10
        $rose(ref_due_reg) |-> ##[1:40] (state_reg == ST_CBR_CAS)) else $error("refresh not issued");
    exit_cas_a: assert property (@(posedge clk) disable iff (rst) // RL16
        state_reg == ST_SELF_HI && state_next == ST_EXIT |=> column_strobe_n [*4]) else $error("exit too fast");

    rd_cov: cover property (@(posedge clk) rd_valid);
    lw_cov: cover property (@(posedge clk) state_reg == ST_WLATE);
    cbr_cov: cover property (@(posedge clk) state_reg == ST_CBR_RAS && init_done_reg);
    self_cov: cover property (@(posedge clk) state_reg == ST_EXIT);
    exit_cov: cover property (@(posedge clk) state_reg == ST_CBR_CAS && $past(state_reg) == ST_EXIT);
endmodule

// File: tb/dram_model.sv
// behavioural model of the 4m x 1 dram as seen at its strobes
`timescale 1ns/1ns
module dram_model
    import dram_host_pkg::*;
(
    // strobes and address
    input  wire logic              row_strobe_n,
    input  wire logic              column_strobe_n,
    input  wire logic              write_strobe_n,
    input  wire logic [ADDR_W-1:0] addr,
    // data
    input  wire logic              din,
    output logic                   dout,
    // observation for the bench
    output int                     ras_count,
    output int                     cbr_count,
    output int                     viol_count,
    output logic                   test_mode
);
    bit                mem [int];
    logic [ADDR_W-1:0] row_reg;
    logic              early_reg;
    logic              exit_reg;
    int                key_reg;
    int                cbr_in_cas;
    realtime           ras_fall_t;
    realtime           ras_rise_t;
    realtime           cas_fall_t;
    realtime           cas_rise_t;
    initial begin
        dout = 1'b0;
        ras_count = 0;
        cbr_count = 0;
        viol_count = 0;
        test_mode = 1'b0;
        exit_reg = 1'b0;
        early_reg = 1'b0;
        cbr_in_cas = 0;
    end
    // ----------------------------------------
    // row strobe: row latch, refresh counter, self-refresh pacing
    // ----------------------------------------
    always @(negedge row_strobe_n) begin
        ras_count++;
        if (exit_reg && $realtime - cas_rise_t < EXIT_ROW_NS) viol_count++;
        exit_reg = 1'b0;
        if (column_strobe_n == 1'b0) begin
            if (write_strobe_n == 1'b0) test_mode = 1'b1;
            cbr_count++;
            if (cbr_in_cas > 0 && $realtime - ras_fall_t > 1.0e6 / SELF_RATE_KHZ) viol_count++;
            if (cbr_in_cas > 0 && $realtime - ras_fall_t < SELF_CYCLE_NS) viol_count++;
            if (cbr_in_cas > 0 && $realtime - ras_rise_t < SELF_HIGH_NS) viol_count++;
            cbr_in_cas++;
        end else begin
            row_reg = addr;
        end
        ras_fall_t = $realtime;
    end
    always @(posedge row_strobe_n) begin
        ras_rise_t = $realtime;
        if (cbr_in_cas > 1 && ras_rise_t - ras_fall_t < SELF_LOW_NS) viol_count++;
    end
    // ----------------------------------------
    // column strobe: access kind and output
    // ----------------------------------------
    always @(negedge column_strobe_n) begin
        if (exit_reg && $realtime - cas_rise_t < EXIT_CAS_NS) viol_count++;
        cas_fall_t = $realtime;
        cbr_in_cas = 0;
        if (row_strobe_n == 1'b0) begin
            early_reg = ~write_strobe_n;
            key_reg = int'({row_reg, addr});
            if (early_reg) mem[key_reg] = din;
            // early write keeps the output off; shown as a flipping line, not a held value
            dout = early_reg ? ~dout : (mem.exists(key_reg) ? mem[key_reg] : 1'b0);
        end
    end
    always @(posedge column_strobe_n) begin
        if (cbr_in_cas > 1 && $realtime - cas_fall_t < SELF_CAS_NS) viol_count++;
        if (cbr_in_cas > 1) exit_reg = 1'b1;
        cas_rise_t = $realtime;
        dout = ~dout;
    end
    // delayed write takes data at the write strobe fall
    always @(negedge write_strobe_n) begin
        if (!row_strobe_n && !column_strobe_n && !early_reg) mem[key_reg] = din;
    end
endmodule

// File: tb/test_dram_host.sv
// self-checking testbench for the dram host controller
`timescale 1ns/1ns
module test_dram_host
    import dram_host_pkg::*;
();
    localparam int PWR   = 20;
    localparam int RFR   = 60;
    localparam int LIMIT = 10000;
    logic              clk, rst, req_valid, req_write, req_late, req_wdata, self_req;
    logic [ADDR_W-1:0] req_row, req_col, addr;
    logic              req_ready, rd_valid, rd_data, mem_ready, in_self, test_mode;
    logic              row_strobe_n, column_strobe_n, write_strobe_n, din, dout;
    int                ras_count, cbr_count, viol_count, fail_count, compares, cycles, c0;
    dram_host #(.POWERUP_CYCLES(PWR), .REFRESH_CYCLES(RFR)) dram_host_i (
        .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_late(req_late), .req_row(req_row), .req_col(req_col),
        .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .self_req(self_req),
        .mem_ready(mem_ready), .in_self(in_self), .row_strobe_n(row_strobe_n),
        .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n), .addr(addr),
        .din(din), .dout(dout));
    dram_model dram_model_i (
        .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
        .write_strobe_n(write_strobe_n), .addr(addr), .din(din), .dout(dout),
        .ras_count(ras_count), .cbr_count(cbr_count), .viol_count(viol_count),
        .test_mode(test_mode));
    initial begin
        clk = 1'b0;
        forever #(CLK_NS / 2) clk = ~clk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
            fail_count++;
        end
    endtask
    // request held until taken; a read then waits for its answer
    task automatic access(input logic w, late, input logic [ADDR_W-1:0] r, c, input logic d);
        int n;
        req_write <= w;
        req_late <= late;
        req_row <= r;
        req_col <= c;
        req_wdata <= d;
        req_valid <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 500);
        req_valid <= 1'b0;
        check("request taken", 1, n < 500);
        n = 0;
        while (!w && rd_valid !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        if (!w) begin
            check("read valid", 1, rd_valid);
            check("read data", {31'h0, d}, {31'h0, rd_data});
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_powerup;
        int n;
        repeat (PWR - 2) @(posedge clk);
        check("strobes during pause", 0, ras_count);
        n = 0;
        while (mem_ready !== 1'b1 && n < 1000) begin @(posedge clk); n++; end
        check("mem ready", 1, mem_ready);
        check("wake strobes", 1, ras_count >= WAKE_STROBES);
        check("first refresh", 1, cbr_count >= 1);
        check("test mode", 0, test_mode);
        $display("test powerup done");
    endtask
    task automatic t_access;
        access(1'b1, 1'b0, 11'h005, 11'h007, 1'b1);
        access(1'b1, 1'b0, 11'h005, 11'h008, 1'b0);
        access(1'b1, 1'b1, 11'h7FF, 11'h7FF, 1'b1);
        access(1'b0, 1'b0, 11'h005, 11'h007, 1'b1);
        access(1'b0, 1'b0, 11'h005, 11'h008, 1'b0);
        access(1'b0, 1'b0, 11'h7FF, 11'h7FF, 1'b1);
        access(1'b1, 1'b1, 11'h005, 11'h007, 1'b0);
        access(1'b0, 1'b0, 11'h005, 11'h007, 1'b0);
        check("timing faults", 0, viol_count);
        $display("test access done");
    endtask
    task automatic t_refresh;
        c0 = cbr_count;
        repeat (RFR * 10) @(posedge clk);
        check("refresh count", 1, cbr_count - c0 >= 9 && cbr_count - c0 <= 11);
        check("test mode", 0, test_mode);
        $display("test refresh done");
    endtask
    task automatic t_self;
        int n;
        self_req <= 1'b1;
        n = 0;
        while (in_self !== 1'b1 && n < 100) begin @(posedge clk); n++; end
        check("in self", 1, in_self);
        c0 = cbr_count;
        repeat (SELF_PERIOD_CYC * 5) @(posedge clk);
        check("self pulses", 1, cbr_count - c0 >= 4 && cbr_count - c0 <= 6);
        self_req <= 1'b0;
        n = 0;
        while (in_self !== 1'b0 && n < 400) begin @(posedge clk); n++; end
        check("left self", 0, in_self);
        access(1'b0, 1'b0, 11'h7FF, 11'h7FF, 1'b1);
        check("timing faults", 0, viol_count);
        check("test mode", 0, test_mode);
        $display("test self done");
    endtask
    // ----------------------------------------
    // run and watchdog
    // ----------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_late = 1'b0;
        req_wdata = 1'b0;
        req_row = '0;
        req_col = '0;
        self_req = 1'b0;
        fail_count = 0;
        compares = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_powerup();
        t_access();
        t_refresh();
        t_self();
        end_sim();
    end
endmodule
